// ---- hdl/pfms_defines.svh ----
/*
 Offsets, field positions, reset values and response codes for the port
 function mode select block. Assumes inclusion by its bare name.
*/
`ifndef PFMS_DEFINES_SVH
`define PFMS_DEFINES_SVH
`define PFMS_NUM_PORTS 12
`define PFMS_FSEL_HI 15
`define PFMS_FSEL_LO 12
`define PFMS_CFG_RESET 16'h0000
`define PFMS_CFG_BASE 12'h000
`define PFMS_DAC_BASE 12'h040
`define PFMS_MASK_ADDR 12'h080
`define PFMS_MODE_ADDR 12'h084
`define PFMS_DATA_ADDR 12'h088
`define PFMS_EVENT_ADDR 12'h08c
`define PFMS_DRIVE_ADDR 12'h090
`define PFMS_RESP_OKAY 2'b00
`define PFMS_RESP_SLVERR 2'b10
`endif

// ---- hdl/pfms_pkg.sv ----
/*
 Types for the port function mode select block.
 Assumes the defines header is compiled alongside.
*/
package pfms_pkg;
  typedef enum logic [3:0] {
    PFMS_MODE_HIZ = 4'h0,
    PFMS_MODE_GPI = 4'h1,
    PFMS_MODE_XLAT = 4'h2
  } pfms_mode_t;

  // Per-port pin control bundle
  typedef struct packed {
    logic drive_en;
    logic sense_en;
    logic xlat_en;
  } pfms_pinctl_t;

  typedef enum {PFMS_W_IDLE, PFMS_W_RESP} pfms_wstate_t;
endpackage

// ---- hdl/pfms_top.sv ----
/*
 Function-mode select for twelve mixed-signal ports, register access over
 AXI4-Lite, threshold compare results and input event capture.
 Assumes synchronous comparator inputs and a single 200 MHz clock.
*/
// Behaviour
// - Twelve ports, mode field bits 15:12
// - Code 0000 neither drives nor senses
// - Code 0001 compares pin against DAC threshold
// - Compare result readable in data register
// - Masked ports capture no new input events
// - Code 0010 pairs port with next port, except on ports 5 and 11
// - Translator activity seen through input path
`timescale 1ns/1ps
`include "pfms_defines.svh"
module pfms_top import pfms_pkg::*; #(
  parameter int NPORT = `PFMS_NUM_PORTS
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPORT-1:0] cmp_above_in,
  output logic [NPORT*12-1:0] threshold_out,
  output logic [NPORT-1:0] sense_en_out,
  output logic [NPORT-1:0] xlat_en_out,
  output logic [NPORT-1:0] drive_en_out
);
  logic [15:0] cfg_r [NPORT];
  logic [11:0] dac_r [NPORT];
  logic [NPORT-1:0] mask_r;
  logic [NPORT-1:0] mode_r;
  logic [NPORT-1:0] level_r;
  logic [NPORT-1:0] event_r;
  logic [NPORT-1:0] event_nxt;
  logic [NPORT-1:0] level_nxt;
  logic [NPORT-1:0] sense_en;
  logic [NPORT-1:0] xlat_en;
  logic [NPORT-1:0] drive_en;
  logic [NPORT-1:0] sense_en_r;
  logic [NPORT-1:0] xlat_en_r;
  logic [NPORT-1:0] drive_en_r;
  logic [NPORT*12-1:0] thr_r;
  pfms_pinctl_t pinctl [NPORT];

  // Write channel capture, address and data accepted in either order
  pfms_wstate_t wstate_r;
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;

  // Held halves wait here until their partner arrives
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_addr = aw_take ? s_axi_awaddr : awaddr_r;
  assign wr_data = w_take ? s_axi_wdata : wdata_r;
  assign wr_strb = w_take ? s_axi_wstrb : wstrb_r;
  assign wr_fire = (wstate_r == PFMS_W_IDLE) && (aw_take || aw_held_r) && (w_take || w_held_r);

  // Write address decode
  logic [NPORT-1:0] cfg_sel;
  logic [NPORT-1:0] dac_sel;
  logic mask_sel;
  logic mode_sel;
  logic event_sel;
  logic [NPORT-1:0] ev_clr;
  assign mask_sel = wr_addr == `PFMS_MASK_ADDR;
  assign mode_sel = wr_addr == `PFMS_MODE_ADDR;
  assign event_sel = wr_addr == `PFMS_EVENT_ADDR;
  assign ev_clr = (wr_fire && event_sel && wr_strb[0]) ? wr_data[NPORT-1:0] : '0;
  logic ro_sel;
  // Read-only addresses answer OKAY and change nothing
  assign ro_sel = (wr_addr == `PFMS_DATA_ADDR) || (wr_addr == `PFMS_DRIVE_ADDR);
  assign wr_hit = (|cfg_sel) || (|dac_sel) || mask_sel || mode_sel || event_sel || ro_sel;

  // Read address decode
  logic [31:0] rd_data;
  logic rd_hit;
  logic [31:0] rd_cfg;
  logic [31:0] rd_dac;
  logic cfg_rd_hit;
  logic dac_rd_hit;
  logic [3:0] rd_idx;
  logic mask_rd_sel;
  logic mode_rd_sel;
  logic data_rd_sel;
  logic event_rd_sel;
  logic drive_rd_sel;

  // Indexed banks; an index past the last port is unmapped
  assign rd_idx = s_axi_araddr[5:2];
  assign cfg_rd_hit = (s_axi_araddr[11:6] == 6'(`PFMS_CFG_BASE >> 6)) && (rd_idx < NPORT)
                      && (s_axi_araddr[1:0] == 2'b00);
  assign dac_rd_hit = (s_axi_araddr[11:6] == 6'(`PFMS_DAC_BASE >> 6)) && (rd_idx < NPORT)
                      && (s_axi_araddr[1:0] == 2'b00);
  assign rd_cfg = cfg_rd_hit ? {16'h0000, cfg_r[rd_idx]} : 32'h0000_0000;
  assign rd_dac = dac_rd_hit ? {20'h00000, dac_r[rd_idx]} : 32'h0000_0000;
  // Single-word registers
  assign mask_rd_sel = s_axi_araddr == `PFMS_MASK_ADDR;
  assign mode_rd_sel = s_axi_araddr == `PFMS_MODE_ADDR;
  assign data_rd_sel = s_axi_araddr == `PFMS_DATA_ADDR;
  assign event_rd_sel = s_axi_araddr == `PFMS_EVENT_ADDR;
  assign drive_rd_sel = s_axi_araddr == `PFMS_DRIVE_ADDR;
  assign rd_hit = cfg_rd_hit || dac_rd_hit || mask_rd_sel || mode_rd_sel || data_rd_sel
                  || event_rd_sel || drive_rd_sel;
  // Banks and words never overlap, so an OR merges them
  assign rd_data = rd_cfg | rd_dac
                   | (mask_rd_sel ? {20'h00000, mask_r} : 32'h0000_0000)
                   | (mode_rd_sel ? {20'h00000, mode_r} : 32'h0000_0000)
                   | (data_rd_sel ? {20'h00000, level_r} : 32'h0000_0000)
                   | (event_rd_sel ? {20'h00000, event_r} : 32'h0000_0000)
                   | (drive_rd_sel ? {20'h00000, drive_en_r} : 32'h0000_0000);

  // Per-port mode decode, config and threshold storage
  // A lower port in code 0010 silences its upper neighbour outright
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      logic [3:0] fsel;
      logic lower_xlat;
      logic ev_set;
      logic ev_keep;

      assign cfg_sel[gi] = wr_addr == 12'(`PFMS_CFG_BASE + gi * 4);
      assign dac_sel[gi] = wr_addr == 12'(`PFMS_DAC_BASE + gi * 4);
      assign fsel = cfg_r[gi][`PFMS_FSEL_HI:`PFMS_FSEL_LO];
      if (gi > 0) begin : g_low
        assign lower_xlat = cfg_r[gi-1][`PFMS_FSEL_HI:`PFMS_FSEL_LO] == PFMS_MODE_XLAT;
      end else begin : g_none
        assign lower_xlat = 1'b0;
      end
      // Code 0000 and unknown codes: pin idle
      assign pinctl[gi].sense_en = !lower_xlat && ((fsel == PFMS_MODE_GPI) || (fsel == PFMS_MODE_XLAT));
      // Translator needs an upper partner; ports 5 and 11 have none
      assign pinctl[gi].xlat_en = !lower_xlat && (fsel == PFMS_MODE_XLAT) && (gi % 6 != 5);
      assign pinctl[gi].drive_en = !lower_xlat && pinctl[gi].xlat_en;
      assign sense_en[gi] = pinctl[gi].sense_en;
      assign xlat_en[gi] = pinctl[gi].xlat_en;
      assign drive_en[gi] = pinctl[gi].drive_en;
      // Input event: result change on an armed, unmasked port
      assign ev_set = sense_en[gi] && mode_r[gi] && !mask_r[gi] && (cmp_above_in[gi] != level_r[gi]);
      // Set wins over a same-cycle clear
      assign ev_keep = event_r[gi] && !ev_clr[gi];
      assign event_nxt[gi] = ev_set || ev_keep;
      // Configuration and DAC registers with byte lanes
      always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cfg_r[gi] <= `PFMS_CFG_RESET;
          dac_r[gi] <= 12'h000;
        end else if (wr_fire) begin
          if (cfg_sel[gi]) begin
            if (wr_strb[0]) cfg_r[gi][7:0] <= wr_data[7:0];
            if (wr_strb[1]) cfg_r[gi][15:8] <= wr_data[15:8];
          end
          if (dac_sel[gi]) begin
            if (wr_strb[0]) dac_r[gi][7:0] <= wr_data[7:0];
            if (wr_strb[1]) dac_r[gi][11:8] <= wr_data[11:8];
          end
        end
      end
      assign thr_r[gi*12 +: 12] = dac_r[gi];
    end
  endgenerate

  // Unsensed ports read zero in the result register
  assign level_nxt = cmp_above_in & sense_en;

  // Mask, mode, result and event bits
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_r <= '0;
      mode_r <= '0;
      level_r <= '0;
      event_r <= '0;
    end else begin
      if (wr_fire && mask_sel && wr_strb[0]) mask_r <= wr_data[NPORT-1:0];
      if (wr_fire && mode_sel && wr_strb[0]) mode_r <= wr_data[NPORT-1:0];
      level_r <= level_nxt;
      event_r <= event_nxt;
    end
  end

  // Registered pin controls
  // Pins follow a mode change one edge after the config write
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sense_en_r <= '0;
      xlat_en_r <= '0;
      drive_en_r <= '0;
    end else begin
      sense_en_r <= sense_en;
      xlat_en_r <= xlat_en;
      drive_en_r <= drive_en;
    end
  end
  assign sense_en_out = sense_en_r;
  assign xlat_en_out = xlat_en_r;
  assign drive_en_out = drive_en_r;
  assign threshold_out = thr_r;

  // Write handshake
  // Readies drop once a half is taken and return after the response
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wstate_r <= PFMS_W_IDLE;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PFMS_RESP_OKAY;
    end else begin
      if (aw_take) awaddr_r <= s_axi_awaddr;
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      case (wstate_r)
        PFMS_W_IDLE: begin
          if (wr_fire) begin
            wstate_r <= PFMS_W_RESP;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PFMS_RESP_OKAY : `PFMS_RESP_SLVERR;
          end else begin
            aw_held_r <= aw_held_r || aw_take;
            w_held_r <= w_held_r || w_take;
            s_axi_awready <= !(aw_held_r || aw_take);
            s_axi_wready <= !(w_held_r || w_take);
          end
        end
        PFMS_W_RESP: begin
          if (s_axi_bready) begin
            wstate_r <= PFMS_W_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
          end
        end
        default: wstate_r <= PFMS_W_IDLE;
      endcase
    end
  end

  // Read handshake
  // One read in flight; arready returns the cycle after rready
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PFMS_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? `PFMS_RESP_OKAY : `PFMS_RESP_SLVERR;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// ---- sim/pfms_checker.sv ----
/*
 Port assertions for pfms_top.
 Bound into every pfms_top instance; single clock domain.
*/
`timescale 1ns/1ps
module pfms_checker #(parameter int NPORT = 12) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPORT-1:0] sense_en_out,
  input wire logic [NPORT-1:0] xlat_en_out,
  input wire logic [NPORT-1:0] drive_en_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // Upper partner of every translator pair
  wire logic [NPORT-1:0] upper_w = {xlat_en_out[NPORT-2:0], 1'b0};
  // Pin control relations
  chk_drive_only_xlat: assert property ((drive_en_out & ~xlat_en_out) == '0) else $error("drive off pair");
  chk_xlat_senses: assert property ((xlat_en_out & ~sense_en_out) == '0) else $error("pair not sensed");
  chk_upper_idle: assert property ((upper_w & (sense_en_out | xlat_en_out | drive_en_out)) == '0)
    else $error("upper port active");
  chk_edge_ports: assert property (!xlat_en_out[5] && !xlat_en_out[NPORT-1]) else $error("pair on edge");
  // Register bus answers
  chk_write_turn: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("no write answer");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  chk_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read answer");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
  chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  chk_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  cover property (|xlat_en_out);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready && |s_axi_rdata);
endmodule

bind pfms_top pfms_checker #(.NPORT(NPORT)) pfms_checker_i (.clock_in, .nrst_in, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sense_en_out, .xlat_en_out, .drive_en_out);

// ---- sim/pfms_pins_model.sv ----
/*
 Comparators behind the external port pins.
 Assumes levels from the bench and thresholds from pfms_top.
*/
`timescale 1ns/1ps
module pfms_pins_model #(parameter int NPORT = 12) (
  input wire logic clock_in,
  input wire logic [NPORT*12-1:0] level_in,
  input wire logic [NPORT*12-1:0] threshold_in,
  input wire logic [NPORT-1:0] sense_en_in,
  output logic [NPORT-1:0] cmp_above_out
);
  logic [NPORT-1:0] noise_r = '0;
  // Unsensed pins float and toggle
  always @(posedge clock_in) noise_r <= ~noise_r;
  // Pin above threshold reads one
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      cmp_above_out[i] = sense_en_in[i] ? level_in[i*12+:12] > threshold_in[i*12+:12] : noise_r[i];
    end
  end
endmodule

// ---- sim/tb_top.sv ----
/*
 Self-checking bench for pfms_top: bus master, reference model, pins.
 Assumes defines, package, design, checker and pin model compiled first.
*/
`timescale 1ns/1ps
`include "pfms_defines.svh"
module tb_top;
  localparam int NP = 12;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, got, seed = 32'hbab26be9;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [NP-1:0] cmp_above_in, sense_en_out, xlat_en_out, drive_en_out, oldc;
  logic [NP*12-1:0] threshold_out, lvl = '0;
  int n_errors = 0, n_checks = 0;
  int code[NP], cfg[NP], th[NP];
  pfms_top #(.NPORT(NP)) pfms_top_i (.clock_in, .nrst_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_above_in,
    .threshold_out, .sense_en_out, .xlat_en_out, .drive_en_out);
  pfms_pins_model #(.NPORT(NP)) pfms_pins_model_i (.clock_in, .level_in(lvl), .threshold_in(threshold_out),
    .sense_en_in(sense_en_out), .cmp_above_out(cmp_above_in));
  // Clock
  initial forever #2.5 clock_in = ~clock_in;
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected input results
  function automatic logic [NP-1:0] dexp();
    logic [NP-1:0] e;
    for (int i = 0; i < NP; i++) e[i] = (code[i] == 1 || code[i] == 2) && lvl[i*12+:12] > th[i];
    return e;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bus write; bready stands from the request until bvalid
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Bus read; data taken at the edge where rvalid stands
  task automatic rd(input logic [11:0] a);
    @(posedge clock_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic newlvl();
    for (int i = 0; i < NP; i++) lvl[i*12+:12] <= 12'(rnd());
    repeat (4) @(posedge clock_in);
  endtask
  // Pin controls against the model
  task automatic pins();
    logic [NP-1:0] es, ex;
    for (int i = 0; i < NP; i++) begin
      es[i] = code[i] == 1 || code[i] == 2;
      ex[i] = code[i] == 2;
    end
    chk(32'(sense_en_out), 32'(es));
    chk(32'(xlat_en_out), 32'(ex));
    chk(32'(drive_en_out), 32'(ex));
    rd(`PFMS_DRIVE_ADDR);
    chk(got, 32'(ex));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rd(`PFMS_CFG_BASE);
    chk(got, 32'(`PFMS_CFG_RESET));
    rd(12'h0fc);
    chk(32'(resp), 32'(`PFMS_RESP_SLVERR));
    wr(12'h0fc, 32'hffff_ffff);
    chk(32'(resp), 32'(`PFMS_RESP_SLVERR));
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < NP; i++) wr(12'(`PFMS_CFG_BASE + 4 * i), 32'h0);
      for (int i = 0; i < NP; i++) begin
        code[i] = rnd() % 4;
        if (i > 0 && code[i-1] == 2) code[i] = 0;
        if ((i == 5 || i == 11) && code[i] == 2) code[i] = 1;
        cfg[i] = (code[i] << 12) | (rnd() & 32'hfff);
        th[i] = rnd() & 32'hfff;
        wr(12'(`PFMS_DAC_BASE + 4 * i), 32'(th[i]));
        wr(12'(`PFMS_CFG_BASE + 4 * i), 32'(cfg[i]));
        chk(32'(resp), 32'(`PFMS_RESP_OKAY));
      end
      newlvl();
      pins();
      for (int i = 0; i < NP; i++) begin
        rd(12'(`PFMS_CFG_BASE + 4 * i));
        chk(32'(got[15:0]), 32'(cfg[i]));
        chk(32'(threshold_out[i*12+:12]), 32'(th[i]));
      end
      rd(`PFMS_DATA_ADDR);
      chk(got, 32'(dexp()));
    end
    // Masked, then unmasked event capture
    wr(`PFMS_MASK_ADDR, 32'hfff);
    wr(`PFMS_MODE_ADDR, 32'hfff);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(`PFMS_MASK_ADDR, 32'h0);
      wr(`PFMS_EVENT_ADDR, 32'hfff);
      oldc = dexp();
      newlvl();
      rd(`PFMS_EVENT_ADDR);
      chk(got, k == 1 ? 32'(oldc ^ dexp()) : 32'h0);
    end
    // Write one to clear, levels now steady
    wr(`PFMS_EVENT_ADDR, 32'hfff);
    rd(`PFMS_EVENT_ADDR);
    chk(got, 32'h0);
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
endmodule
